// *** design/occ_pkg.sv ***
package occ_pkg;
  localparam int N_OUT = 4;
  localparam int N_LOOP = 2;
  localparam int AW = 8;
  localparam int N_CFG = 10;
  localparam int NVM_PASSES = 2;

  // ----------------------------------------
  // Register indices, byte address is four times these
  // ----------------------------------------
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_MAP_PRI = 6'h01;
  localparam logic [5:0] IDX_MAP_SEC = 6'h02;
  localparam logic [5:0] IDX_REG_EN = 6'h03;
  localparam logic [5:0] IDX_DIS_STATE = 6'h04;
  localparam logic [5:0] IDX_POLARITY = 6'h05;
  localparam logic [5:0] IDX_FORMAT = 6'h06;
  localparam logic [5:0] IDX_AMPL = 6'h07;
  localparam logic [5:0] IDX_DRIVE = 6'h08;
  localparam logic [5:0] IDX_LOOP_SEL = 6'h09;
  localparam logic [5:0] IDX_CMD = 6'h0A;
  localparam logic [5:0] IDX_STATUS = 6'h0B;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_SYNC_DIS = 0;
  localparam int CTRL_LOL_DIS = 1;
  localparam int CTRL_LOS_KEEP = 2;
  localparam int CMD_HARD_RST = 0;
  localparam int CMD_NVM_PROG = 1;
  localparam int AMPL_W = 3;
  localparam int DRV_W = 2;
  localparam int DIS_W = 2;

  localparam logic [1:0] DRV_NONE = 2'h0;
  localparam logic [1:0] DRV_WEAK = 2'h1;
  localparam logic [1:0] DIS_LOW = 2'h0;
  localparam logic [1:0] DIS_HIGH = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Power-up defaults when memory is blank
  // ----------------------------------------
  localparam logic [N_CFG-1:0][31:0] CFG_DEFAULT = {
    32'h0000_0000, 32'h0000_00FF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_000F, 32'h0000_0000, 32'h0000_000F, 32'h0000_0001};

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int DIV_RST_NS = 100;
  localparam int DIV_RST_CYC = (DIV_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] DIV_RST_LAST = 8'(DIV_RST_CYC - 1);
  localparam logic [7:0] DIV_HALF_LAST = 8'h01;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_DIVRST = 2'b01,
    ST_RUN = 2'b10
  } init_state_t;
endpackage : occ_pkg

// *** design/out_driver.sv ***
`timescale 1ns/1ps
module out_driver (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic div_rst,
  input wire logic want_en,
  input wire logic sync_mode,
  input wire logic [1:0] dis_state,
  input wire logic invert,
  input wire logic complement,
  input wire logic single_ended,
  output logic pin_true,
  output logic pin_comp,
  output logic pin_oe
);
  typedef struct packed {
    logic [7:0] cnt;
    logic phase;
    logic on;
    logic pt;
    logic pc;
    logic oe;
  } drv_t;

  drv_t s;
  drv_t next_s;
  logic lvl;

  always_comb begin
    next_s = s;
    lvl = 1'b0;
    // ----------------------------------------
    // Divider
    // ----------------------------------------
    if (div_rst) begin
      next_s.cnt = '0;
      next_s.phase = 1'b0;
    end else if (tick) begin
      if (s.cnt == occ_pkg::DIV_HALF_LAST) begin
        next_s.cnt = '0;
        next_s.phase = ~s.phase;
      end else begin
        next_s.cnt = s.cnt + 8'h01;
      end
    end
    // ----------------------------------------
    // Enable timing
    // ----------------------------------------
    // Turning on also waits for a low phase so the first pulse is whole
    if (want_en) begin
      if (!next_s.phase) begin
        next_s.on = 1'b1;
      end
    end else if (!sync_mode) begin
      next_s.on = 1'b0;
    end else if (!next_s.phase) begin
      next_s.on = 1'b0;
    end
    // ----------------------------------------
    // Pin levels
    // ----------------------------------------
    if (next_s.on) begin
      lvl = next_s.phase ^ invert;
      next_s.pt = lvl;
      next_s.pc = single_ended ? (lvl ^ complement) : ~lvl;
      next_s.oe = 1'b1;
    end else begin
      next_s.pt = (dis_state == occ_pkg::DIS_HIGH);
      next_s.pc = (dis_state == occ_pkg::DIS_HIGH);
      next_s.oe = (dis_state == occ_pkg::DIS_LOW) || (dis_state == occ_pkg::DIS_HIGH);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pin_true = s.pt;
  assign pin_comp = s.pc;
  assign pin_oe = s.oe;

  a_async_off: assert property (@(posedge ref_clk) disable iff (rst)
    (!want_en && !sync_mode) |=> !s.on)
    else $error("async disable did not act at once");
  a_sync_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (s.on && s.phase && !want_en && sync_mode && !div_rst && !tick) |=> s.on)
    else $error("sync disable cut a high phase");
  a_hiz_state: assert property (@(posedge ref_clk) disable iff (rst)
    (!s.on && $past(dis_state) != occ_pkg::DIS_LOW
      && $past(dis_state) != occ_pkg::DIS_HIGH) |-> !s.oe)
    else $error("disabled high impedance driver still drives");
  a_se_phase: assert property (@(posedge ref_clk) disable iff (rst)
    (s.on && $past(single_ended) && !$past(complement)) |-> (s.pt == s.pc))
    else $error("single ended pins not in phase");
endmodule : out_driver

// *** design/output_enable_control.sv ***
`timescale 1ns/1ps
module output_enable_control (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic primary_enable_pin_n,
  input wire logic secondary_enable_pin_n,
  input wire logic [1:0] lock_lost,
  input wire logic reference_loss_alarm,
  input wire logic serial_sel,
  input wire logic [3:0] low_supply,
  input wire logic [1:0] loop_tick,
  output logic [3:0] clock_output_n_true,
  output logic [3:0] clock_output_n_comp,
  output logic [3:0] clock_output_n_oe,
  output logic [11:0] amplitude_code,
  output logic [3:0] low_power_mode,
  output logic [3:0] single_ended,
  output logic [7:0] single_ended_drive_strength,
  output logic div_reset
);
  typedef struct packed {
    logic [occ_pkg::N_CFG-1:0][31:0] cfg;
    occ_pkg::init_state_t st;
    logic [7:0] cnt;
    logic [occ_pkg::N_OUT-1:0] en;
    logic div_rst;
    logic aw_full;
    logic w_full;
    logic [5:0] aw_idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_t;

  ctl_t s;
  ctl_t next_s;
  logic [occ_pkg::N_CFG-1:0][31:0] nvm_mem;
  logic [1:0] nvm_passes;
  logic nvm_prog;
  logic hard_rst;
  logic [occ_pkg::N_OUT-1:0] pin_block;
  logic [occ_pkg::N_OUT-1:0] lol_gate;
  logic [occ_pkg::N_OUT-1:0] reg_en;
  logic [occ_pkg::N_OUT-1:0] map_pri;
  logic [occ_pkg::N_OUT-1:0] map_sec;
  logic [occ_pkg::N_OUT-1:0] loop_sel;
  logic los_gate;
  logic wr_go;
  logic [31:0] ctrl;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [5:0] reg_idx(input logic [7:0] addr);
    return addr[7:2];
  endfunction : reg_idx

  function automatic logic idx_ok(input logic [5:0] idx);
    return idx <= occ_pkg::IDX_STATUS;
  endfunction : idx_ok

  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Illegal codes leave the field unchanged rather than raising an error
  function automatic logic [31:0] fix_drive(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] low);
    logic [31:0] r;
    logic [1:0] c;
    r = old_w;
    for (int i = 0; i < occ_pkg::N_OUT; i++) begin
      c = new_w[occ_pkg::DRV_W*i +: occ_pkg::DRV_W];
      if (c != occ_pkg::DRV_NONE && !(low[i] && c == occ_pkg::DRV_WEAK)) begin
        r[occ_pkg::DRV_W*i +: occ_pkg::DRV_W] = c;
      end
    end
    return r;
  endfunction : fix_drive

  // ----------------------------------------
  // Enable gating
  // ----------------------------------------
  assign ctrl = s.cfg[occ_pkg::IDX_CTRL];
  assign map_pri = s.cfg[occ_pkg::IDX_MAP_PRI][occ_pkg::N_OUT-1:0];
  assign map_sec = s.cfg[occ_pkg::IDX_MAP_SEC][occ_pkg::N_OUT-1:0];
  assign reg_en = s.cfg[occ_pkg::IDX_REG_EN][occ_pkg::N_OUT-1:0];
  assign loop_sel = s.cfg[occ_pkg::IDX_LOOP_SEL][occ_pkg::N_OUT-1:0];
  assign pin_block = (map_pri & {occ_pkg::N_OUT{primary_enable_pin_n}})
                   | (map_sec & {occ_pkg::N_OUT{secondary_enable_pin_n}});
  assign los_gate = reference_loss_alarm && !ctrl[occ_pkg::CTRL_LOS_KEEP];

  always_comb begin
    for (int i = 0; i < occ_pkg::N_OUT; i++) begin
      lol_gate[i] = ctrl[occ_pkg::CTRL_LOL_DIS] && lock_lost[loop_sel[i]];
    end
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign wr_go = s.aw_full && s.w_full && !s.bvalid;
  assign hard_rst = wr_go && s.aw_idx == occ_pkg::IDX_CMD && s.wstrb[0]
                    && s.wdata[occ_pkg::CMD_HARD_RST];
  // Programming only from a settled image, and never past the pass limit
  assign nvm_prog = wr_go && s.aw_idx == occ_pkg::IDX_CMD && s.wstrb[0]
                    && s.wdata[occ_pkg::CMD_NVM_PROG] && s.st == occ_pkg::ST_RUN
                    && nvm_passes < 2'(occ_pkg::NVM_PASSES);

  always_comb begin
    next_s = s;
    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_full = 1'b1;
      next_s.aw_idx = reg_idx(s_axi_awaddr);
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_full = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = idx_ok(s.aw_idx) ? occ_pkg::RESP_OKAY : occ_pkg::RESP_SLVERR;
      if (s.aw_idx == occ_pkg::IDX_DRIVE) begin
        next_s.cfg[s.aw_idx] = fix_drive(s.cfg[s.aw_idx],
                                         merge(s.cfg[s.aw_idx], s.wdata, s.wstrb), low_supply);
      end else if (s.aw_idx < 6'(occ_pkg::N_CFG)) begin
        next_s.cfg[s.aw_idx] = merge(s.cfg[s.aw_idx], s.wdata, s.wstrb);
      end
    end
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready = !next_s.w_full && !next_s.bvalid;
    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = occ_pkg::RESP_OKAY;
      next_s.rdata = '0;
      if (!idx_ok(reg_idx(s_axi_araddr))) begin
        next_s.rresp = occ_pkg::RESP_SLVERR;
      end else if (reg_idx(s_axi_araddr) == occ_pkg::IDX_STATUS) begin
        next_s.rdata = {21'h0, serial_sel, nvm_passes,
                        s.st == occ_pkg::ST_RUN, reference_loss_alarm, lock_lost, s.en};
      end else if (reg_idx(s_axi_araddr) < 6'(occ_pkg::N_CFG)) begin
        next_s.rdata = s.cfg[reg_idx(s_axi_araddr)];
      end
    end
    next_s.arready = !next_s.rvalid;
    // ----------------------------------------
    // Initialisation sequence
    // ----------------------------------------
    case (s.st)
      occ_pkg::ST_LOAD: begin
        // Blank memory falls back to the built-in defaults
        next_s.cfg[s.cnt[5:0]] = (nvm_passes == 2'h0) ? occ_pkg::CFG_DEFAULT[s.cnt[5:0]]
                                 : nvm_mem[s.cnt[5:0]];
        if (s.cnt == 8'(occ_pkg::N_CFG - 1)) begin
          next_s.st = occ_pkg::ST_DIVRST;
          next_s.cnt = '0;
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      occ_pkg::ST_DIVRST: begin
        if (s.cnt == occ_pkg::DIV_RST_LAST) begin
          next_s.st = occ_pkg::ST_RUN;
          next_s.cnt = '0;
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      occ_pkg::ST_RUN: begin
        next_s.cnt = '0;
      end
      default: begin
        next_s.st = occ_pkg::ST_LOAD;
        next_s.cnt = '0;
      end
    endcase
    if (hard_rst) begin
      next_s.st = occ_pkg::ST_LOAD;
      next_s.cnt = '0;
    end
    next_s.div_rst = (next_s.st != occ_pkg::ST_RUN);
    next_s.en = {occ_pkg::N_OUT{s.st == occ_pkg::ST_RUN && !los_gate}}
                & reg_en & ~pin_block & ~lol_gate;
  end

  // Reset lands in the load state with all outputs off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Non-volatile image, untouched by the reset pin
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (por) begin
      nvm_passes <= 2'h0;
    end else if (nvm_prog) begin
      nvm_mem <= s.cfg;
      nvm_passes <= nvm_passes + 2'h1;
    end
  end

  // ----------------------------------------
  // Output drivers
  // ----------------------------------------
  for (genvar i = 0; i < occ_pkg::N_OUT; i++) begin : g_out
    out_driver u_drv (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(loop_tick[loop_sel[i]]),
      .div_rst(s.div_rst),
      .want_en(s.en[i]),
      .sync_mode(ctrl[occ_pkg::CTRL_SYNC_DIS]),
      .dis_state(s.cfg[occ_pkg::IDX_DIS_STATE][occ_pkg::DIS_W*i +: occ_pkg::DIS_W]),
      .invert(s.cfg[occ_pkg::IDX_POLARITY][occ_pkg::N_OUT + i]),
      .complement(s.cfg[occ_pkg::IDX_POLARITY][i]),
      .single_ended(s.cfg[occ_pkg::IDX_FORMAT][i]),
      .pin_true(clock_output_n_true[i]),
      .pin_comp(clock_output_n_comp[i]),
      .pin_oe(clock_output_n_oe[i])
    );
  end

  assign amplitude_code = s.cfg[occ_pkg::IDX_AMPL][occ_pkg::N_OUT*occ_pkg::AMPL_W-1:0];
  assign low_power_mode = s.cfg[occ_pkg::IDX_FORMAT][2*occ_pkg::N_OUT-1:occ_pkg::N_OUT];
  assign single_ended = s.cfg[occ_pkg::IDX_FORMAT][occ_pkg::N_OUT-1:0];
  assign single_ended_drive_strength = s.cfg[occ_pkg::IDX_DRIVE][7:0];
  assign div_reset = s.div_rst;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_pin_gate: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> (s.en & $past(pin_block)) == '0)
    else $error("output enabled while its mapped pin is high");
  a_reg_enable: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> (s.en & ~$past(reg_en)) == '0)
    else $error("output enabled with register enable clear");
  a_los_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (reference_loss_alarm && !ctrl[occ_pkg::CTRL_LOS_KEEP]) |=> s.en == '0)
    else $error("outputs on during reference loss");
  a_lol_gate: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> (s.en & $past(lol_gate)) == '0)
    else $error("output on during lock loss with gating set");
  a_load_first: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st != occ_pkg::ST_RUN) |=> s.en == '0)
    else $error("output enabled before load completed");
  a_div_reset: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == occ_pkg::ST_DIVRST) |-> div_reset ##0 (s.cnt <= occ_pkg::DIV_RST_LAST))
    else $error("divider reset not held during initialisation");
  a_hard_reset: assert property (@(posedge ref_clk) disable iff (rst)
    hard_rst |=> (s.st == occ_pkg::ST_LOAD && div_reset) ##1 div_reset)
    else $error("hard reset bit did not restart initialisation");
  a_nvm_limit: assert property (@(posedge ref_clk) disable iff (rst || por)
    (nvm_passes == 2'(occ_pkg::NVM_PASSES)) |=> (nvm_passes == 2'(occ_pkg::NVM_PASSES)))
    else $error("memory programmed beyond two passes");
  a_drive_legal: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == occ_pkg::ST_RUN && $past(wr_go) && $past(s.aw_idx) == occ_pkg::IDX_DRIVE)
      |-> s.cfg[occ_pkg::IDX_DRIVE][occ_pkg::DRV_W-1:0] != occ_pkg::DRV_NONE)
    else $error("drive strength field holds code zero");
  a_write_resp: assert property (@(posedge ref_clk) disable iff (rst)
    wr_go |=> s.bvalid && !s.awready && !s.wready)
    else $error("write response missing");
endmodule : output_enable_control

// *** testbench/loop_source.sv ***
`timescale 1ns/1ps
module loop_source (
  input wire logic ref_clk,
  input wire logic [1:0] lol_req,
  input wire logic los_req,
  output logic [1:0] loop_tick,
  output logic [1:0] lock_lost,
  output logic reference_loss_alarm
);
  // ----------------------------------------
  // Two loops at unlike rates
  // ----------------------------------------
  logic [2:0] cnt = 3'h0;

  initial begin
    loop_tick = 2'h0;
    lock_lost = 2'h0;
    reference_loss_alarm = 1'h0;
  end

  // Ticks keep going while unlocked: free-run stands in for holdover
  always @(posedge ref_clk) begin
    cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
    loop_tick <= {(cnt == 3'h0 || cnt == 3'h3), ~cnt[0]};
    lock_lost <= lol_req;
    reference_loss_alarm <= los_req;
  end
endmodule : loop_source

// *** testbench/output_enable_control_tb.sv ***
`timescale 1ns/1ps
module output_enable_control_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct packed {logic [31:0] mask; logic [31:0] data; logic [1:0] resp;} note_t;
  localparam logic [1:0] OK = occ_pkg::RESP_OKAY;
  localparam logic [1:0] BAD = occ_pkg::RESP_SLVERR;
  logic ref_clk = 1'h0, rst = 1'h1, por = 1'h1, serial_sel = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
  logic [3:0] s_axi_wstrb = 4'hF, low_supply = 4'h0, last_t;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, los_req = 1'h0;
  logic primary_enable_pin_n = 1'h1, secondary_enable_pin_n = 1'h1;
  logic [1:0] lol_req = 2'h0, lock_lost, loop_tick, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic reference_loss_alarm, div_reset;
  logic [3:0] clock_output_n_true, clock_output_n_comp, clock_output_n_oe;
  logic [3:0] low_power_mode, single_ended;
  logic [11:0] amplitude_code;
  logic [7:0] single_ended_drive_strength;
  note_t rd_q[$];
  note_t wr_q[$];
  int err_total = 0, checks = 0, seed = 98, i, k;
  int hi_len = 0, cut_len = 0;
  // Whole high half of output 0, loop 0 ticking every other cycle
  localparam int HALF0 = 2 * (int'(occ_pkg::DIV_HALF_LAST) + 1);

  always #5 ref_clk = ~ref_clk;

  output_enable_control uut (.ref_clk, .rst, .por, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .primary_enable_pin_n,
    .secondary_enable_pin_n, .lock_lost, .reference_loss_alarm, .serial_sel, .low_supply,
    .loop_tick, .clock_output_n_true, .clock_output_n_comp, .clock_output_n_oe,
    .amplitude_code, .low_power_mode, .single_ended, .single_ended_drive_strength, .div_reset);

  loop_source partner (.ref_clk, .lol_req, .los_req, .loop_tick, .lock_lost,
    .reference_loss_alarm);

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic tmo();
    err_total++;
    $display("unexpected wait: expected finish, seen timeout");
    complete_run();
  endtask : tmo

  task automatic cmp_pin(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : cmp_pin

  task automatic cmp_bus(input string name, input note_t e, input logic [1:0] resp,
                         input logic [31:0] data);
    checks++;
    if (resp !== e.resp || (data & e.mask) !== e.data) begin
      err_total++;
      $display("unexpected %s: expected %h/%h, seen %h/%h", name, e.resp, e.data, resp,
               data & e.mask);
    end
  endtask : cmp_bus

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : step

  // Valids drop only at their own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    wr_q.push_back('{32'h0, 32'h0, er});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 200) tmo();
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    rd_q.push_back('{m, d, er});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 200) tmo();
    @(posedge ref_clk);
  endtask : rd

  task automatic wait_oe(input logic [3:0] exp);
    int n;
    for (n = 0; n < 100 && clock_output_n_oe !== exp; n++) @(posedge ref_clk);
    if (n == 100) tmo();
    cmp_pin("oe", 32'(exp), 32'(clock_output_n_oe));
  endtask : wait_oe

  // Returns just after output 0 rose, at the start of a high half
  task automatic wait_rise();
    int n;
    last_t = clock_output_n_true;
    for (n = 0; n < 20 && !(clock_output_n_true[0] && !last_t[0]); n++) begin
      last_t = clock_output_n_true;
      @(posedge ref_clk);
    end
    if (n == 20) tmo();
  endtask : wait_rise

  task automatic wait_init();
    int n;
    for (n = 0; n < 100 && div_reset !== 1'h1; n++) @(posedge ref_clk);
    cmp_pin("div_reset", 32'h1, 32'(div_reset));
    for (n = 0; n < 100 && div_reset !== 1'h0; n++) @(posedge ref_clk);
    if (n == 100) tmo();
    step(2);
    rd(8'h2C, 32'h80, 32'h80, OK);
  endtask : wait_init

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (s_axi_bvalid && s_axi_bready) cmp_bus("write", wr_q.pop_front(), s_axi_bresp, 32'h0);
    if (s_axi_rvalid && s_axi_rready) cmp_bus("read", rd_q.pop_front(), s_axi_rresp, s_axi_rdata);
  end

  // High run of output 0 when its driver lets go; a cut run is a runt
  always @(posedge ref_clk) begin
    hi_len <= (clock_output_n_oe[0] && clock_output_n_true[0]) ? hi_len + 1 : 0;
    if (!clock_output_n_oe[0] && hi_len != 0) cut_len <= hi_len;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    step(6);
    rst <= 1'h0;
    por <= 1'h0;
    wait_init();
    for (i = 0; i < 10; i++) rd(8'(i * 4), 32'hFFFFFFFF, occ_pkg::CFG_DEFAULT[i], OK);
    wr(8'h10, 32'hAA, OK);
    primary_enable_pin_n <= 1'h0;
    wait_oe(4'hF);
    wr(8'h0C, 32'hE, OK);
    wait_oe(4'hE);
    step(1);
    cmp_pin("runt", 32'h0, 32'(cut_len % HALF0));
    wr(8'h0C, 32'hF, OK);
    wr(8'h04, 32'hD, OK);
    wr(8'h08, 32'h2, OK);
    wait_oe(4'hD);
    secondary_enable_pin_n <= 1'h0;
    wait_oe(4'hF);
    primary_enable_pin_n <= 1'h1;
    wait_oe(4'h2);
    primary_enable_pin_n <= 1'h0;
    wr(8'h28, 32'h2, OK);
    step(20);
    rd(8'h2C, 32'h300, 32'h100, OK);
    wr(8'h00, 32'h0, OK);
    wait_rise();
    primary_enable_pin_n <= 1'h1;
    step(3);
    cmp_pin("oe async", 32'h2, 32'(clock_output_n_oe));
    primary_enable_pin_n <= 1'h0;
    wr(8'h00, 32'h1, OK);
    los_req <= 1'h1;
    wait_oe(4'h0);
    wr(8'h00, 32'h5, OK);
    wait_oe(4'hF);
    los_req <= 1'h0;
    wr(8'h24, 32'hC, OK);
    lol_req <= 2'h2;
    step(20);
    cmp_pin("oe lock", 32'hF, 32'(clock_output_n_oe));
    wr(8'h00, 32'h3, OK);
    wait_oe(4'h3);
    lol_req <= 2'h0;
    wait_oe(4'hF);
    wr(8'h00, 32'h1, OK);
    for (i = 0; i < 3; i++) begin
      wr(8'h10, {24'h0, 6'h2A, 2'(i)}, OK);
      wr(8'h0C, 32'hE, OK);
      step(20);
      cmp_pin("oe0 off", 32'(i != 2), 32'(clock_output_n_oe[0]));
      if (i != 2) cmp_pin("true0 off", 32'(i == 1), 32'(clock_output_n_true[0]));
      wr(8'h0C, 32'hF, OK);
    end
    wr(8'h10, 32'hAA, OK);
    wr(8'h18, 32'h1, OK);
    for (i = 0; i < 2; i++) begin
      wr(8'h14, 32'(i), OK);
      for (k = 0; k < 8; k++) begin
        step(1);
        cmp_pin("comp0", 32'(clock_output_n_true[0] ^ i[0]), 32'(clock_output_n_comp[0]));
      end
    end
    for (i = 0; i < 3; i++) begin
      rnd = $random(seed);
      wr(8'h1C, {20'h0, rnd[11:0]}, OK);
      wr(8'h18, {24'h0, rnd[19:12]}, OK);
      cmp_pin("amplitude", 32'(rnd[11:0]), 32'(amplitude_code));
      cmp_pin("low power", 32'(rnd[19:16]), 32'(low_power_mode));
      cmp_pin("single", 32'(rnd[15:12]), 32'(single_ended));
      rd(8'h1C, 32'hFFF, {20'h0, rnd[11:0]}, OK);
    end
    low_supply <= 4'h1;
    wr(8'h20, 32'hE5, OK);
    cmp_pin("drive", 32'hE7, 32'(single_ended_drive_strength));
    wr(8'h20, 32'h27, OK);
    rd(8'h20, 32'hFFFFFFFF, 32'hE7, OK);
    wr(8'h28, 32'h1, OK);
    wait_init();
    rd(8'h04, 32'hFFFFFFFF, 32'hD, OK);
    rd(8'h08, 32'hFFFFFFFF, 32'h2, OK);
    for (i = 0; i < 2; i++) begin
      wr(8'h28, 32'h2, OK);
      step(20);
    end
    rd(8'h2C, 32'h300, 32'h200, OK);
    wr(8'h30, 32'h1, BAD);
    rd(8'h30, 32'hFFFFFFFF, 32'h0, BAD);
    rst <= 1'h1;
    step(2);
    rst <= 1'h0;
    wait_init();
    rd(8'h08, 32'hFFFFFFFF, 32'h2, OK);
    step(5);
    complete_run();
  end
endmodule : output_enable_control_tb
